// ==== emcb_pkg.sv ====
// Notes on behaviour
// - Gain ramp starts after code times 204.8 us
// - 120 user bits stored, nonvolatile, never used
// - Ringdown watch window is code times 25.6 us
// - Drive current code loaded from nonvolatile after reset
// - Tolerance codes give 2.34, 5.4, 8.2, 12.5 percent
// - Logging starts at code times 25.6 us
// - Sample period 25.6 to 204.8 us, reset code 1
// - Auto mode: base period first and after update
// - Measured period used only inside tolerance
// - Indirect auto measurement receives on base period
// - Squelch zeroes magnitudes below noise level
// - Offset subtracted from each flight time result
package emcb_pkg;
	localparam int CLK_HZ = 50_000_000;
	localparam real STEP_TIME_US = 25.6;
	localparam real GAIN_STEP_US = 204.8;
	localparam int STEP_CYCLES = int'(STEP_TIME_US * CLK_HZ / 1.0e6);
	localparam int GAIN_STEP_TICKS = int'(GAIN_STEP_US / STEP_TIME_US);

	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam logic [3:0] IDX_GAIN = 4'h0;
	localparam logic [3:0] IDX_USER0 = 4'h1;
	localparam logic [3:0] IDX_USER1 = 4'h2;
	localparam logic [3:0] IDX_USER2 = 4'h3;
	localparam logic [3:0] IDX_USER3 = 4'h4;
	localparam logic [3:0] IDX_WATCH = 4'h5;
	localparam logic [3:0] IDX_LOG = 4'h6;
	localparam logic [3:0] IDX_BASE_PER = 4'h7;
	localparam logic [3:0] IDX_TX_PER = 4'h8;
	localparam logic [3:0] IDX_RX_PER = 4'h9;
	localparam logic [3:0] IDX_STATUS = 4'hA;

	// Field positions inside IDX_GAIN, IDX_WATCH and IDX_LOG
	localparam int POS_DRIVE = 8;
	localparam int POS_TOL = 14;
	localparam int POS_INTERVAL = 12;
	localparam int POS_AUTO = 14;
	localparam int POS_SQUELCH = 15;
	localparam int POS_OFFSET = 16;
	localparam int POS_FILTER = 4;

	localparam logic [3:0] RST_GAIN_DELAY = 4'h0;
	localparam logic [1:0] RST_FILTER = 2'h0;
	localparam logic [11:0] RST_LOG_BEGIN = 12'h000;
	localparam logic [1:0] RST_INTERVAL = 2'h1;
	localparam logic [15:0] RST_PERIOD = 16'h0000;

	// Tolerance limits in hundredths of a percent
	localparam logic [13:0] TOL_0 = 14'd234;
	localparam logic [13:0] TOL_1 = 14'd540;
	localparam logic [13:0] TOL_2 = 14'd820;
	localparam logic [13:0] TOL_3 = 14'd1250;
	localparam logic [13:0] TOL_SCALE = 14'd10000;

	typedef struct packed {
		logic [3:0] gain_ramp_delay;
		logic [1:0] gain_ramp_filter_width;
		logic [119:0] free_scratch_bits;
		logic [7:0] ringdown_watch_length;
		logic [5:0] drive_current_code;
		logic [1:0] ringdown_period_tolerance;
		logic [11:0] log_window_begin;
		logic [1:0] log_sample_interval;
		logic auto_carrier_select;
		logic below_noise_squelch;
		logic [5:0] flight_time_offset;
		logic [15:0] base_carrier_period;
		logic [15:0] transmit_carrier_period;
		logic [15:0] receive_carrier_period;
	} emcb_cfg_t;

	// Image of the nonvolatile fields
	typedef struct packed {
		logic [119:0] free_scratch_bits;
		logic [7:0] ringdown_watch_length;
		logic [5:0] drive_current_code;
		logic [1:0] ringdown_period_tolerance;
		logic auto_carrier_select;
		logic below_noise_squelch;
		logic [5:0] flight_time_offset;
	} emcb_nv_t;
endpackage

// ==== emcb_tick.sv ====
`timescale 1ns/1ps
`default_nettype none
module emcb_tick #(
	parameter int CYCLES = 1280
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic clr,
	output logic tick
);
	logic [$clog2(CYCLES)-1:0] cnt_q;
	logic [$clog2(CYCLES)-1:0] cnt_d;

	assign tick = !clr && (cnt_q == ($clog2(CYCLES))'(CYCLES - 1));

	always_comb begin
		if (clr || tick) begin
			cnt_d = '0;
		end else begin
			cnt_d = cnt_q + 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end
endmodule // emcb_tick
`default_nettype wire

// ==== emcb_top.sv ====
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module emcb_top
	import emcb_pkg::*;
#(
	parameter int TICK_CYCLES = STEP_CYCLES,
	parameter int LOG_DEPTH = 128
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [DATA_W-1:0] rdata,
	input wire emcb_nv_t nv_image,
	output emcb_nv_t nv_store_data,
	output logic nv_store,
	input wire logic meas_start,
	input wire logic meas_indirect,
	input wire logic meas_stop,
	input wire logic period_valid,
	input wire logic [15:0] measured_ringdown_period,
	input wire logic mag_valid,
	input wire logic [7:0] echo_mag,
	input wire logic [7:0] noise_level,
	input wire logic tof_valid,
	input wire logic [15:0] tof_raw,
	output logic [15:0] tx_period,
	output logic [15:0] rx_period,
	output logic [5:0] drive_current,
	output logic [1:0] gain_filter_width,
	output logic gain_ramp_go,
	output logic watch_active,
	output logic log_we,
	output logic [$clog2(LOG_DEPTH)-1:0] log_addr,
	output logic [7:0] log_data,
	output logic [15:0] tof_result,
	output logic tof_result_valid
);
	localparam int LA_W = $clog2(LOG_DEPTH);

	function automatic logic [13:0] tol_limit(input logic [1:0] code);
		case (code)
			2'h0: tol_limit = TOL_0;
			2'h1: tol_limit = TOL_1;
			2'h2: tol_limit = TOL_2;
			default: tol_limit = TOL_3;
		endcase
	endfunction

	typedef enum logic [1:0] {EMCB_IDLE, EMCB_RUN, EMCB_FULL} emcb_state_t;

	emcb_cfg_t cfg_q, cfg_d;
	logic load_pend_q, load_pend_d;
	logic nv_store_q, nv_store_d;
	logic [DATA_W-1:0] rdata_q, rdata_d;
	emcb_state_t state_q, state_d;
	logic [15:0] elapsed_q, elapsed_d;
	logic [7:0] phase_q, phase_d;
	logic first_done_q, first_done_d;
	logic period_ok_q, period_ok_d;
	logic [15:0] last_period_q, last_period_d;
	logic [15:0] tx_q, tx_d, rx_q, rx_d;
	logic log_we_q, log_we_d;
	logic [LA_W-1:0] log_addr_q, log_addr_d;
	logic [7:0] log_data_q, log_data_d;
	logic [15:0] tof_q, tof_d;
	logic tof_v_q, tof_v_d;
	logic tick;
	logic running;
	logic sample_due;
	logic [15:0] diff;
	logic [29:0] lhs, rhs;

	emcb_tick #(.CYCLES(TICK_CYCLES)) u_tick (
		.clk(clk),
		.rst(rst),
		.clr(meas_start),
		.tick(tick)
	);

	// Register file
	always_comb begin
		cfg_d = cfg_q;
		nv_store_d = 1'b0;
		load_pend_d = 1'b0;
		if (load_pend_q) begin
			{cfg_d.free_scratch_bits, cfg_d.ringdown_watch_length, cfg_d.drive_current_code,
				cfg_d.ringdown_period_tolerance, cfg_d.auto_carrier_select,
				cfg_d.below_noise_squelch, cfg_d.flight_time_offset} = nv_image;
		end else if (wr_en) begin
			// Nonvolatile words are stored back
			nv_store_d = (addr >= IDX_USER0) && (addr <= IDX_LOG);
			if (addr == IDX_GAIN) begin
				cfg_d.gain_ramp_delay = wdata[3:0];
				cfg_d.gain_ramp_filter_width = wdata[POS_FILTER +: 2];
			end else if (addr == IDX_USER0) begin
				cfg_d.free_scratch_bits[31:0] = wdata;
			end else if (addr == IDX_USER1) begin
				cfg_d.free_scratch_bits[63:32] = wdata;
			end else if (addr == IDX_USER2) begin
				cfg_d.free_scratch_bits[95:64] = wdata;
			end else if (addr == IDX_USER3) begin
				cfg_d.free_scratch_bits[119:96] = wdata[23:0];
			end else if (addr == IDX_WATCH) begin
				cfg_d.ringdown_watch_length = wdata[7:0];
				cfg_d.drive_current_code = wdata[POS_DRIVE +: 6];
				cfg_d.ringdown_period_tolerance = wdata[POS_TOL +: 2];
			end else if (addr == IDX_LOG) begin
				cfg_d.log_window_begin = wdata[11:0];
				cfg_d.log_sample_interval = wdata[POS_INTERVAL +: 2];
				cfg_d.auto_carrier_select = wdata[POS_AUTO];
				cfg_d.below_noise_squelch = wdata[POS_SQUELCH];
				cfg_d.flight_time_offset = wdata[POS_OFFSET +: 6];
			end else if (addr == IDX_BASE_PER) begin
				cfg_d.base_carrier_period = wdata[15:0];
			end else if (addr == IDX_TX_PER) begin
				cfg_d.transmit_carrier_period = wdata[15:0];
			end else if (addr == IDX_RX_PER) begin
				cfg_d.receive_carrier_period = wdata[15:0];
			end
		end
		rdata_d = '0;
		if (rd_en) begin
			if (addr == IDX_GAIN) begin
				rdata_d = {26'h0, cfg_q.gain_ramp_filter_width, cfg_q.gain_ramp_delay};
			end else if (addr == IDX_USER0) begin
				rdata_d = cfg_q.free_scratch_bits[31:0];
			end else if (addr == IDX_USER1) begin
				rdata_d = cfg_q.free_scratch_bits[63:32];
			end else if (addr == IDX_USER2) begin
				rdata_d = cfg_q.free_scratch_bits[95:64];
			end else if (addr == IDX_USER3) begin
				rdata_d = {8'h0, cfg_q.free_scratch_bits[119:96]};
			end else if (addr == IDX_WATCH) begin
				rdata_d = {16'h0, cfg_q.ringdown_period_tolerance, cfg_q.drive_current_code,
					cfg_q.ringdown_watch_length};
			end else if (addr == IDX_LOG) begin
				rdata_d = {10'h0, cfg_q.flight_time_offset, cfg_q.below_noise_squelch,
					cfg_q.auto_carrier_select, cfg_q.log_sample_interval, cfg_q.log_window_begin};
			end else if (addr == IDX_BASE_PER) begin
				rdata_d = {16'h0, cfg_q.base_carrier_period};
			end else if (addr == IDX_TX_PER) begin
				rdata_d = {16'h0, cfg_q.transmit_carrier_period};
			end else if (addr == IDX_RX_PER) begin
				rdata_d = {16'h0, cfg_q.receive_carrier_period};
			end else if (addr == IDX_STATUS) begin
				rdata_d = {tof_q, 4'h0, (state_q != EMCB_IDLE), period_ok_q, first_done_q,
					(state_q == EMCB_FULL), log_addr_q[LA_W-1:0] & 8'hFF};
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg_q <= '0;
			cfg_q.gain_ramp_delay <= RST_GAIN_DELAY;
			cfg_q.gain_ramp_filter_width <= RST_FILTER;
			cfg_q.log_window_begin <= RST_LOG_BEGIN;
			cfg_q.log_sample_interval <= RST_INTERVAL;
			cfg_q.base_carrier_period <= RST_PERIOD;
			load_pend_q <= 1'b1;
			nv_store_q <= 1'b0;
			rdata_q <= '0;
		end else begin
			cfg_q <= cfg_d;
			load_pend_q <= load_pend_d;
			nv_store_q <= nv_store_d;
			rdata_q <= rdata_d;
		end
	end

	assign rdata = rdata_q;
	assign nv_store = nv_store_q;
	assign nv_store_data = {cfg_q.free_scratch_bits, cfg_q.ringdown_watch_length,
		cfg_q.drive_current_code, cfg_q.ringdown_period_tolerance,
		cfg_q.auto_carrier_select, cfg_q.below_noise_squelch, cfg_q.flight_time_offset};
	assign drive_current = cfg_q.drive_current_code;
	assign gain_filter_width = cfg_q.gain_ramp_filter_width;

	// Measurement sequencer
	assign running = (state_q != EMCB_IDLE);
	assign diff = (measured_ringdown_period > cfg_q.base_carrier_period) ?
		(measured_ringdown_period - cfg_q.base_carrier_period) :
		(cfg_q.base_carrier_period - measured_ringdown_period);
	assign lhs = diff * TOL_SCALE;
	assign rhs = cfg_q.base_carrier_period * tol_limit(cfg_q.ringdown_period_tolerance);
	assign sample_due = (state_q == EMCB_RUN) && tick &&
		(elapsed_q >= {4'h0, cfg_q.log_window_begin}) &&
		(phase_q == 8'h00);

	always_comb begin
		state_d = state_q;
		elapsed_d = elapsed_q;
		phase_d = phase_q;
		first_done_d = first_done_q;
		period_ok_d = period_ok_q;
		last_period_d = last_period_q;
		tx_d = tx_q;
		rx_d = rx_q;
		log_we_d = 1'b0;
		log_addr_d = log_addr_q;
		log_data_d = log_data_q;
		tof_v_d = 1'b0;
		tof_d = tof_q;
		if (meas_start) begin
			state_d = EMCB_RUN;
			elapsed_d = '0;
			phase_d = '0;
			log_addr_d = '0;
			if (cfg_q.auto_carrier_select) begin
				tx_d = (first_done_q && period_ok_q) ? last_period_q : cfg_q.base_carrier_period;
				rx_d = meas_indirect ? cfg_q.base_carrier_period : tx_d;
				first_done_d = 1'b1;
			end else begin
				tx_d = cfg_q.transmit_carrier_period;
				rx_d = cfg_q.receive_carrier_period;
			end
		end else if (running) begin
			if (meas_stop) begin
				state_d = EMCB_IDLE;
			end
			if (tick && elapsed_q != 16'hFFFF) begin
				elapsed_d = elapsed_q + 16'h1;
			end
			if (tick && elapsed_q >= {4'h0, cfg_q.log_window_begin}) begin
				phase_d = (phase_q == ((8'h1 << cfg_q.log_sample_interval) - 8'h1)) ?
					8'h00 : phase_q + 8'h1;
			end
			if (sample_due) begin
				log_we_d = 1'b1;
				log_data_d = (cfg_q.below_noise_squelch && echo_mag < noise_level) ?
					8'h00 : echo_mag;
				if (log_addr_q == LA_W'(LOG_DEPTH - 1)) begin
					state_d = meas_stop ? EMCB_IDLE : EMCB_FULL;
				end
			end
			if (log_we_q) begin
				log_addr_d = log_addr_q + 1'b1;
			end
		end
		if (period_valid) begin
			last_period_d = measured_ringdown_period;
			period_ok_d = (lhs < rhs);
		end
		if (wr_en && !load_pend_q && addr == IDX_BASE_PER) begin
			first_done_d = 1'b0;
		end
		if (tof_valid) begin
			tof_d = (tof_raw > {10'h0, cfg_q.flight_time_offset}) ?
				tof_raw - {10'h0, cfg_q.flight_time_offset} : 16'h0000;
			tof_v_d = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= EMCB_IDLE;
			elapsed_q <= '0;
			phase_q <= '0;
			first_done_q <= 1'b0;
			period_ok_q <= 1'b0;
			last_period_q <= '0;
			tx_q <= '0;
			rx_q <= '0;
			log_we_q <= 1'b0;
			log_addr_q <= '0;
			log_data_q <= '0;
			tof_q <= '0;
			tof_v_q <= 1'b0;
		end else begin
			state_q <= state_d;
			elapsed_q <= elapsed_d;
			phase_q <= phase_d;
			first_done_q <= first_done_d;
			period_ok_q <= period_ok_d;
			last_period_q <= last_period_d;
			tx_q <= tx_d;
			rx_q <= rx_d;
			log_we_q <= log_we_d;
			log_addr_q <= log_addr_d;
			log_data_q <= log_data_d;
			tof_q <= tof_d;
			tof_v_q <= tof_v_d;
		end
	end

	assign gain_ramp_go = running &&
		(elapsed_q >= 16'(cfg_q.gain_ramp_delay * GAIN_STEP_TICKS));
	assign watch_active = running && (elapsed_q < {8'h0, cfg_q.ringdown_watch_length});
	assign tx_period = tx_q;
	assign rx_period = rx_q;
	assign log_we = log_we_q;
	assign log_addr = log_addr_q;
	assign log_data = log_data_q;
	assign tof_result = tof_q;
	assign tof_result_valid = tof_v_q;

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	property p_gain_go;
		running && !meas_start && !wr_en && elapsed_q < 16'(cfg_q.gain_ramp_delay * GAIN_STEP_TICKS)
			|=> !gain_ramp_go || meas_start || $past(tick);
	endproperty
	a_gain_go: assert property (p_gain_go) else $error("gain ramp started early");
	property p_watch;
		watch_active |-> elapsed_q < {8'h0, cfg_q.ringdown_watch_length};
	endproperty
	a_watch: assert property (p_watch) else $error("watch window too long");
	property p_preload;
		$fell(load_pend_q) |-> drive_current == $past(nv_image.drive_current_code);
	endproperty
	a_preload: assert property (p_preload) else $error("drive current not preloaded");
	property p_log_start;
		log_we |-> $past(elapsed_q) >= {4'h0, cfg_q.log_window_begin} || $past(wr_en);
	endproperty
	a_log_start: assert property (p_log_start) else $error("logging before start time");
	property p_tx_manual;
		meas_start && !cfg_q.auto_carrier_select
			|=> tx_period == $past(cfg_q.transmit_carrier_period);
	endproperty
	a_tx_manual: assert property (p_tx_manual) else $error("manual tx period wrong");
	property p_tx_auto;
		meas_start && cfg_q.auto_carrier_select && !(first_done_q && period_ok_q)
			|=> tx_period == $past(cfg_q.base_carrier_period);
	endproperty
	a_tx_auto: assert property (p_tx_auto) else $error("auto tx period not base");
	property p_rx_auto;
		meas_start && cfg_q.auto_carrier_select |=> rx_period ==
			($past(meas_indirect) ? $past(cfg_q.base_carrier_period) : tx_period);
	endproperty
	a_rx_auto: assert property (p_rx_auto) else $error("auto rx period not base");
	property p_squelch;
		log_we && cfg_q.below_noise_squelch && !$past(wr_en) && $past(echo_mag < noise_level)
			|-> log_data == 8'h00;
	endproperty
	a_squelch: assert property (p_squelch) else $error("noise not squelched");
	property p_tof;
		tof_valid && tof_raw > {10'h0, cfg_q.flight_time_offset} && !wr_en
			|=> tof_result_valid && tof_result == $past(tof_raw - {10'h0, cfg_q.flight_time_offset});
	endproperty
	a_tof: assert property (p_tof) else $error("offset not subtracted");
	property p_log_addr;
		log_we && !meas_start |=> log_addr == $past(log_addr) + 1'b1;
	endproperty
	a_log_addr: assert property (p_log_addr) else $error("log address not advanced");

	c_log: cover property (log_we ##[1:300] log_we);
	c_auto_measured: cover property (meas_start && cfg_q.auto_carrier_select && first_done_q
		&& period_ok_q);
	c_full: cover property (state_q == EMCB_FULL);
	c_tof: cover property (tof_result_valid);
endmodule // emcb_top
`default_nettype wire

// ==== emcb_nvmem.sv ====
`timescale 1ns/1ps
`default_nettype none
module emcb_nvmem
	import emcb_pkg::*;
#(
	parameter emcb_nv_t INIT = '0
) (
	input wire logic clk,
	input wire emcb_nv_t nv_store_data,
	input wire logic nv_store,
	output emcb_nv_t nv_image
);
	emcb_nv_t mem;

	initial begin
		mem = INIT;
	end
	always @(posedge clk) begin
		if (nv_store) begin
			mem <= nv_store_data;
		end
	end
	assign nv_image = mem;
endmodule // emcb_nvmem
`default_nettype wire

// ==== emcb_top_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module emcb_top_bench;
	import emcb_pkg::*;
	localparam int TK = 4;
	localparam emcb_nv_t NV0 = '{drive_current_code: 6'h2A, default: '0};
	localparam logic [15:0] BASE = 16'h03E8;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] addr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic wr_en, rd_en, nv_store, meas_start, meas_indirect, meas_stop;
	logic period_valid, mag_valid, tof_valid, tof_result_valid;
	logic gain_ramp_go, watch_active, log_we;
	emcb_nv_t nv_image;
	emcb_nv_t nv_store_data;
	logic [15:0] measured_ringdown_period, tof_raw, tx_period, rx_period, tof_result;
	logic [7:0] echo_mag, noise_level, log_data;
	logic [5:0] drive_current;
	logic [1:0] gain_filter_width;
	logic [6:0] log_addr;
	int error_cnt = 0;
	int checks = 0;

	emcb_top #(.TICK_CYCLES(TK), .LOG_DEPTH(128)) dut (.clk, .rst, .addr, .wdata, .wr_en,
		.rd_en, .rdata, .nv_image, .nv_store_data, .nv_store, .meas_start, .meas_indirect,
		.meas_stop, .period_valid, .measured_ringdown_period, .mag_valid, .echo_mag,
		.noise_level, .tof_valid, .tof_raw, .tx_period, .rx_period, .drive_current,
		.gain_filter_width, .gain_ramp_go, .watch_active, .log_we, .log_addr, .log_data,
		.tof_result, .tof_result_valid);
	emcb_nvmem #(.INIT(NV0)) nvm (.clk, .nv_store_data, .nv_store, .nv_image);

	always #10 clk = ~clk;

	task automatic report_and_stop;
		$display("Checks %0d, errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask

	task automatic chk_rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		chk(rdata, e);
	endtask

	task automatic set_watch(input logic [1:0] tol);
		wr(IDX_WATCH, {16'h0, tol, 6'h2A, 8'h03});
	endtask

	// Fixed offset of 5 and log start code 3
	task automatic set_log(input logic [1:0] iv, input logic auto, input logic sq);
		wr(IDX_LOG, {10'h0, 6'h05, sq, auto, iv, 12'h003});
	endtask

	task automatic start(input logic ind);
		@(posedge clk);
		meas_start <= 1'b1;
		meas_indirect <= ind;
		@(posedge clk);
		meas_start <= 1'b0;
		#1;
	endtask

	task automatic stop;
		@(posedge clk);
		meas_stop <= 1'b1;
		@(posedge clk);
		meas_stop <= 1'b0;
	endtask

	task automatic period(input logic [15:0] p);
		@(posedge clk);
		period_valid <= 1'b1;
		measured_ringdown_period <= p;
		@(posedge clk);
		period_valid <= 1'b0;
	endtask

	task automatic tof(input logic [15:0] raw, input logic [15:0] e);
		@(posedge clk);
		tof_valid <= 1'b1;
		tof_raw <= raw;
		@(posedge clk);
		tof_valid <= 1'b0;
		#1;
		chk(32'(tof_result_valid), 32'h1);
		chk(32'(tof_result), 32'(e));
	endtask

	task automatic t_reset_vals;
		chk_rd(IDX_GAIN, 32'h0);
		chk_rd(IDX_LOG, 32'h0000_1000);
		chk_rd(IDX_WATCH, 32'h0000_2A00);
		chk(32'(drive_current), 32'h2A);
		chk_rd(4'hF, 32'h0);
	endtask

	task automatic t_user;
		logic [31:0] ud [4];
		logic [127:0] img;
		ud = '{32'h1234_5678, 32'h9ABC_DEF0, 32'h0F1E_2D3C, 32'h00A5_5AC3};
		for (int i = 0; i < 4; i++) begin
			wr(4'(IDX_USER0 + i), ud[i]);
		end
		repeat (2) @(posedge clk);
		img = {8'h0, nv_image.free_scratch_bits};
		for (int i = 0; i < 4; i++) begin
			chk(img[i*32 +: 32], ud[i]);
		end
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		for (int i = 0; i < 4; i++) begin
			chk_rd(4'(IDX_USER0 + i), ud[i]);
		end
		chk(32'(drive_current), 32'h2A);
	endtask

	task automatic t_tof;
		set_log(2'h1, 1'b0, 1'b0);
		tof(16'h0100, 16'h00FB);
		tof(16'h0003, 16'h0000);
		tof(16'h0005, 16'h0000);
	endtask

	task automatic t_carrier;
		logic [15:0] lo [4];
		logic [15:0] hi [4];
		lo = '{16'd23, 16'd53, 16'd81, 16'd124};
		hi = '{16'd24, 16'd54, 16'd82, 16'd125};
		wr(IDX_TX_PER, 32'h01F4);
		wr(IDX_RX_PER, 32'h0258);
		wr(IDX_BASE_PER, 32'(BASE));
		start(1'b0);
		chk(32'(tx_period), 32'h01F4);
		chk(32'(rx_period), 32'h0258);
		set_log(2'h1, 1'b1, 1'b0);
		wr(IDX_BASE_PER, 32'(BASE));
		start(1'b1);
		chk(32'(tx_period), 32'(BASE));
		chk(32'(rx_period), 32'(BASE));
		for (int c = 0; c < 4; c++) begin
			set_watch(2'(c));
			period(BASE + lo[c]);
			start(1'b1);
			chk(32'(tx_period), 32'(BASE + lo[c]));
			chk(32'(rx_period), 32'(BASE));
			period(BASE - hi[c]);
			start(1'b0);
			chk(32'(tx_period), 32'(BASE));
		end
		period(BASE + lo[3]);
		start(1'b0);
		chk(32'(tx_period), 32'(BASE + lo[3]));
		chk(32'(rx_period), 32'(BASE + lo[3]));
		wr(IDX_BASE_PER, 32'(BASE));
		start(1'b0);
		chk(32'(tx_period), 32'(BASE));
		set_log(2'h1, 1'b0, 1'b0);
	endtask

	task automatic t_timing;
		int ga;
		int wl;
		ga = 0;
		wl = 0;
		wr(IDX_GAIN, 32'h22);
		#1;
		chk(32'(gain_filter_width), 32'h2);
		start(1'b0);
		for (int n = 1; n <= 200; n++) begin
			@(posedge clk);
			#1;
			if (watch_active === 1'b1) wl = n;
			if (gain_ramp_go === 1'b1 && ga == 0) ga = n;
		end
		chk(32'(ga >= 16 * TK - 4 && ga <= 16 * TK + 6), 32'h1);
		chk(32'(wl >= 3 * TK - 4 && wl <= 3 * TK + 6), 32'h1);
		stop();
	endtask

	task automatic t_log;
		int cyc [3];
		logic [6:0] ad [3];
		int k;
		for (int iv = 0; iv < 4; iv++) begin
			set_log(2'(iv), 1'b0, iv[0]);
			start(1'b0);
			k = 0;
			for (int n = 1; n <= 400 && k < 3; n++) begin
				@(posedge clk);
				#1;
				if (log_we === 1'b1) begin
					cyc[k] = n;
					ad[k] = log_addr;
					chk(32'(log_data), iv[0] ? 32'h0 : 32'h30);
					k++;
				end
			end
			if (k < 3) begin
				error_cnt++;
				$display("Error at %0t: logging stalled", $time);
				report_and_stop();
			end
			chk(32'(cyc[1] - cyc[0]), 32'((1 << iv) * TK));
			chk(32'(cyc[2] - cyc[1]), 32'((1 << iv) * TK));
			chk(32'(ad[1]), 32'(ad[0] + 7'h1));
			chk(32'(ad[2]), 32'(ad[1] + 7'h1));
			chk(32'(cyc[0] >= 2 * TK + 1 && cyc[0] <= 4 * TK + 2), 32'h1);
			stop();
		end
	endtask

	initial begin
		addr = 4'h0;
		wdata = 32'h0;
		wr_en = 1'b0;
		rd_en = 1'b0;
		meas_start = 1'b0;
		meas_indirect = 1'b0;
		meas_stop = 1'b0;
		period_valid = 1'b0;
		measured_ringdown_period = 16'h0000;
		mag_valid = 1'b0;
		echo_mag = 8'h30;
		noise_level = 8'h40;
		tof_valid = 1'b0;
		tof_raw = 16'h0000;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		t_reset_vals();
		t_user();
		t_tof();
		t_carrier();
		t_timing();
		t_log();
		report_and_stop();
	end
endmodule // emcb_top_bench
`default_nettype wire
